// ### bench/radio_test_gen_asserts.sv
/*
 Port checks for radio_test_gen.
 Assumes binding into radio_test_gen; one pclk domain.
*/
`timescale 1ns/1ps
module radio_test_gen_asserts (
   // APB side
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata_r,
   input wire logic pready_r,
   // Stream and indicator
   input wire logic [7:0] tx_data_r,
   input wire logic tx_valid_r,
   input wire logic tx_ready,
   input wire logic tx_on_r,
   input wire logic transmit_data_indicator_r,
   // Receiver and settings
   input wire logic rx_frame,
   input wire logic signed [7:0] rssi_dbm,
   input wire logic rx_pass_r,
   input wire logic [31:0] tx_freq_r,
   input wire logic [1:0] spacing_r,
   input wire logic [1:0] power_r
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic acc;
   logic [7:0] last_r;
   logic [1:0] pos_r;
   assign acc = tx_valid_r && tx_ready;
   // Byte position in line; reset with test mode, line abandoned
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn || !transmit_data_indicator_r) begin
         last_r <= 8'h0a;
         pos_r <= 2'h0;
      end else if (acc) begin
         last_r <= tx_data_r;
         pos_r <= (tx_data_r == 8'h0a) ? 2'h0 : ((pos_r == 2'h2) ? 2'h2 : pos_r + 2'h1);
      end
   end
   sequence s_hi_taken;
      acc && pos_r == 2'h0;
   endsequence
   property p_digits; acc && pos_r != 2'h2 |-> tx_data_r inside {[8'h30:8'h39]}; endproperty
   a_digits: assert property (p_digits) else $error("line number byte not a digit");
   property p_lo_next; s_hi_taken ##1 transmit_data_indicator_r |-> tx_valid_r; endproperty
   a_lo_next: assert property (p_lo_next) else $error("second digit late");
   property p_crlf; acc && tx_data_r == 8'h0a |-> last_r == 8'h0d; endproperty
   a_crlf: assert property (p_crlf) else $error("line feed without carriage return");
   property p_hold; (tx_valid_r && !tx_ready) ##1 transmit_data_indicator_r |-> tx_valid_r && $stable(tx_data_r);
   endproperty
   a_hold: assert property (p_hold) else $error("byte dropped while stalled");
   property p_led; tx_on_r |-> transmit_data_indicator_r; endproperty
   a_led: assert property (p_led) else $error("sending with indicator dark");
   property p_start; $rose(presetn) |-> ##[1:2] (tx_valid_r && tx_data_r == 8'h30); endproperty
   a_start: assert property (p_start) else $error("no line after reset");
   property p_rx_idle; !rx_frame |=> !rx_pass_r; endproperty
   a_rx_idle: assert property (p_rx_idle) else $error("pass outside frame");
   property p_rx_weak; $rose(rx_frame) && rssi_dbm < radio_test_pkg::THRESH_MIN |=> !rx_pass_r; endproperty
   a_rx_weak: assert property (p_rx_weak) else $error("weak frame passed");
   property p_rx_strong; $rose(rx_frame) && rssi_dbm >= radio_test_pkg::THRESH_MAX |=> rx_pass_r; endproperty
   a_rx_strong: assert property (p_rx_strong) else $error("strong frame dropped");
   property p_rssi;
      psel && !penable && !pwrite && paddr == radio_test_pkg::OFS_RSSI
         |=> pready_r && prdata_r == {{24{$past(rssi_dbm[7])}}, $past(rssi_dbm)};
   endproperty
   a_rssi: assert property (p_rssi) else $error("level query wrong");
   property p_step;
      $changed(tx_freq_r) |-> tx_freq_r % ((spacing_r == radio_test_pkg::SPC_20K) ?
         radio_test_pkg::FREQ_STEP_WIDE_HZ : radio_test_pkg::FREQ_STEP_FINE_HZ) == 32'h0;
   endproperty
   a_step: assert property (p_step) else $error("frequency off step");
   property p_spacing; spacing_r != 2'h3; endproperty
   a_spacing: assert property (p_spacing) else $error("illegal spacing");
   property p_power; $changed(power_r) |-> $past(psel && penable && pwrite && paddr == radio_test_pkg::OFS_POWER);
   endproperty
   a_power: assert property (p_power) else $error("power changed unasked");
endmodule

// ### bench/rx_modem_model.sv
/*
 Receiving modem model: sinks the test stream, makes received frames.
 Assumes tb drives stall_pct and calls clear and frame.
*/
`timescale 1ns/1ps
module rx_modem_model (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Test stream in
   input wire logic [7:0] tx_data_r,
   input wire logic tx_valid_r,
   output logic tx_ready = 1'b1,
   // Received frames out
   output logic rx_frame = 1'b0,
   output logic signed [7:0] rssi_dbm = -8'sd100
);
   int cyc = 0;
   int stall_pct = 0;
   int seed = 32'h202b;
   bit at_start = 1'b1;
   logic [7:0] bytes[$];
   int starts[$];
   // Sink with random stalls; native framing only
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      tx_ready <= ($unsigned($random(seed)) % 100) >= stall_pct;
      if (!presetn) begin
         at_start = 1'b1;
      end else if (tx_valid_r && tx_ready) begin
         if (at_start) begin
            starts.push_back(cyc);
         end
         bytes.push_back(tx_data_r);
         at_start = (tx_data_r == 8'h0a);
      end
   end
   task automatic clear;
      bytes.delete();
      starts.delete();
      at_start = 1'b1;
   endtask
   // Level changed after frame to expose late sampling
   task automatic frame(input logic [7:0] lvl);
      @(posedge pclk);
      rx_frame <= 1'b1;
      rssi_dbm <= lvl;
      repeat (4) @(posedge pclk);
      rx_frame <= 1'b0;
      rssi_dbm <= ~lvl;
   endtask
endmodule

// ### bench/tb.sv
/*
 Bench for radio_test_gen with a receiving modem model.
 Assumes a short second of SC cycles.
*/
`timescale 1ns/1ps
module tb;
   localparam int SC = 300;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata_r, tx_freq_r, rx_freq_r, rd, f;
   logic pready_r, pslverr_r, tx_valid_r, tx_ready, tx_on_r, transmit_data_indicator_r, rx_frame, rx_pass_r, er;
   logic [7:0] tx_data_r, th;
   logic signed [7:0] rssi_dbm;
   logic [1:0] spacing_r, power_r;
   logic [7:0] lim[4] = '{8'h8a, 8'hb0, 8'h89, 8'hb1};
   int bad_count = 0;
   int compares = 0;
   int seed = 32'h202b;
   int t0, n, step;

   always #5 pclk = ~pclk;

   radio_test_gen #(.SEC_CYCLES(SC)) dut (.*);
   rx_modem_model m (.*);

   task automatic chk(input bit ok, input string msg);
      compares++;
      if (!ok) begin
         bad_count++;
         $display("ERROR %0t: %s", $time, msg);
      end
   endtask
   function automatic logic [31:0] sx(input logic [7:0] v);
      return {{24{v[7]}}, v};
   endfunction
   // One APB transfer; outputs read once settled
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         k++;
      end while (pready_r !== 1'b1 && k < 50);
      chk(k < 50, "no pready");
      rd = prdata_r;
      er = pslverr_r;
      psel <= 1'b0;
      penable <= 1'b0;
      @(negedge pclk);
   endtask
   task automatic frame_chk(input logic [7:0] lvl, input logic exp);
      fork
         m.frame(lvl);
         begin
            @(posedge pclk);
            repeat (2) @(negedge pclk);
            chk(rx_pass_r === exp, "frame gating wrong");
         end
      join
   endtask
   // Checks complete lines
   task automatic check_lines(input bit lng, input int first, output int cnt);
      int i, e, len, base;
      bit ok;
      len = lng ? radio_test_pkg::LONG_LEN : radio_test_pkg::SHORT_LEN;
      base = lng ? radio_test_pkg::SHORT_LEN : 0;
      i = 0;
      cnt = 0;
      while (i + len + 2 <= m.bytes.size()) begin
         e = (first + cnt) % 100;
         chk({m.bytes[i], m.bytes[i + 1]} === {8'(8'h30 + e / 10), 8'(8'h30 + e % 10)}, "line number");
         ok = 1'b1;
         for (int k = 0; k < len; k++) begin
            ok &= m.bytes[i + 2 + k] === radio_test_pkg::TEXT[8 * (radio_test_pkg::TEXT_LEN - base - k) - 1 -: 8];
         end
         chk(ok, "line text");
         if (lng) begin
            chk((m.starts[cnt] - t0 + 5) % (60 * SC) < 50 * SC + 10, "line in pause");
         end else if (cnt > 1) begin
            chk(m.starts[cnt] - m.starts[cnt - 1] === SC, "line period");
         end
         i += len + 2;
         cnt++;
      end
   endtask
   task automatic test_done;
      $display("Counts: %0d compares, %0d mismatches", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // Settings, then short and long lines
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk);
      chk(spacing_r === 2'h0, "spacing reset");
      chk(power_r === 2'h3, "power reset");
      apb(0, radio_test_pkg::OFS_THRESH, 0);
      chk(rd === sx(radio_test_pkg::THRESH_RST), "threshold reset");
      apb(1, 8'h20, 32'h1);
      chk(er === 1'b1, "unmapped write taken");
      for (int p = 0; p < 4; p++) begin
         apb(1, radio_test_pkg::OFS_POWER, p);
         chk(power_r === p[1:0], "power select");
      end
      for (int s = 0; s < 3; s++) begin
         step = (s == 1) ? 10000 : 6250;
         f = step * (40000 + $unsigned($random(seed)) % 20000);
         apb(1, radio_test_pkg::OFS_SPACING, s);
         chk(spacing_r === s[1:0], "spacing select");
         apb(1, radio_test_pkg::OFS_TX_FREQ, f);
         chk(er === 1'b0 && tx_freq_r === f, "on-step freq refused");
         apb(1, radio_test_pkg::OFS_RX_FREQ, f + step / 2 + ((s == 1) ? 1250 : 0));
         chk(er === 1'b1 && rx_freq_r === radio_test_pkg::FREQ_RST_HZ, "off-step freq taken");
      end
      apb(1, radio_test_pkg::OFS_SPACING, 3);
      chk(er === 1'b1 && spacing_r === 2'h2, "spacing code 3 taken");
      for (int i = 0; i < 4; i++) begin
         apb(1, radio_test_pkg::OFS_THRESH, sx(lim[i]));
         chk(er === (i > 1), "threshold range");
      end
      repeat (3) begin
         th = 8'(-118 + $unsigned($random(seed)) % 39);
         apb(1, radio_test_pkg::OFS_THRESH, sx(th));
         frame_chk(th, 1'b1);
         frame_chk(th - 8'h1, 1'b0);
      end
      frame_chk(8'h88, 1'b0);
      frame_chk(8'hba, 1'b1);
      apb(0, radio_test_pkg::OFS_RSSI, 0);
      chk(rd === sx(m.rssi_dbm), "level query");
      $display("Settings test done");
      wait (m.cyc > 5 * SC);
      apb(1, radio_test_pkg::OFS_CTRL, 0);
      repeat (2) @(negedge pclk);
      chk(transmit_data_indicator_r === 1'b0 && tx_valid_r === 1'b0, "test mode still on");
      check_lines(1'b0, 0, n);
      $display("Short block test done");
      m.clear();
      m.stall_pct = 10;
      apb(1, radio_test_pkg::OFS_CTRL, 3);
      t0 = m.cyc;
      @(negedge pclk);
      chk(transmit_data_indicator_r === 1'b1, "indicator dark");
      wait (m.cyc > t0 + 55 * SC);
      @(negedge pclk);
      chk(tx_on_r === 1'b0 && tx_valid_r === 1'b0, "sending in pause");
      wait (m.cyc > t0 + 61 * SC);
      @(negedge pclk);
      chk(tx_on_r === 1'b1, "no restart after pause");
      check_lines(1'b1, n % 100, n);
      chk(n > 100, "too few long lines");
      $display("Long block test done");
      test_done();
   end

   // Watchdog against a hang
   initial begin
      repeat (30000) @(posedge pclk);
      bad_count++;
      $display("ERROR %0t: watchdog expired", $time);
      test_done();
   end
endmodule

bind radio_test_gen radio_test_gen_asserts chk_i (.*);

// ### rtl/radio_test_gen.sv
/*
 Radio test-message generator with radio settings registers on APB.
 Streams numbered test lines to the modem transmitter over valid/ready,
 checks frequency and threshold settings, gates received frames by RSSI.
 Assumes tx_ready, rx_frame and rssi_dbm come from logic on pclk.
*/
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/1ps
module radio_test_gen #(
   parameter int SEC_CYCLES = radio_test_pkg::SEC_CYCLES
) (
   // APB slave
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata_r,
   output logic pready_r,
   output logic pslverr_r,
   // Test byte stream to transmitter
   output logic [7:0] tx_data_r,
   output logic tx_valid_r,
   input wire logic tx_ready,
   output logic tx_on_r,
   // Indicator
   output logic transmit_data_indicator_r,
   // Receiver gating
   input wire logic rx_frame,
   input wire logic signed [7:0] rssi_dbm,
   output logic rx_pass_r,
   // Radio settings to the RF section
   output logic [31:0] tx_freq_r,
   output logic [31:0] rx_freq_r,
   output logic [1:0] spacing_r,
   output logic [1:0] power_r
);

   localparam int AW = 6;
   localparam int SECW = 6;
   localparam logic [AW-1:0] SHORT_BASE = '0;
   localparam logic [AW-1:0] LONG_BASE = AW'(radio_test_pkg::SHORT_LEN);
   localparam logic [AW-1:0] SHORT_LAST = AW'(radio_test_pkg::SHORT_LEN - 1);
   localparam logic [AW-1:0] LONG_LAST = AW'(radio_test_pkg::LONG_LEN - 1);
   localparam logic [SECW-1:0] BURST_END = SECW'(radio_test_pkg::BURST_S);
   localparam logic [SECW-1:0] CYCLE_LAST =
      SECW'(radio_test_pkg::BURST_S + radio_test_pkg::PAUSE_S - 1);

   initial begin
      if (SEC_CYCLES < 2) begin
         $error("radio_test_gen: SEC_CYCLES must be at least 2");
      end
   end

   logic [1:0] ctrl_r;
   logic signed [7:0] thresh_r;
   logic reject_r;
   logic [3:0] seq_hi_r;
   logic [3:0] seq_lo_r;
   logic [SECW-1:0] sec_cnt_r;
   logic line_due_r;
   logic rx_frame_d_r;
   radio_test_pkg::send_state_t state_r;
   logic [AW-1:0] idx_r;
   logic [7:0] rom_data;
   logic sec_tick;

   logic test_en;
   logic long_mode;
   logic wr_acc;
   logic [7:0] woff;
   logic ctrl_wr;
   logic freq_ok;
   logic spc_ok;
   logic thr_ok;
   logic bad_wr;
   logic burst_on;
   logic line_start;
   logic line_done;

   assign test_en = ctrl_r[radio_test_pkg::CTRL_EN_BIT];
   assign long_mode = ctrl_r[radio_test_pkg::CTRL_LONG_BIT];

   // Write takes effect in the access cycle, which is never stretched
   assign wr_acc = psel && penable && pwrite && pready_r;
   assign woff = paddr;
   assign ctrl_wr = wr_acc && (woff == radio_test_pkg::OFS_CTRL);

   // Step depends on the spacing held now, not on a spacing being written
   always_comb begin
      if (spacing_r == radio_test_pkg::SPC_20K) begin
         freq_ok = (pwdata % radio_test_pkg::FREQ_STEP_WIDE_HZ) == 32'h0;
      end else begin
         freq_ok = (pwdata % radio_test_pkg::FREQ_STEP_FINE_HZ) == 32'h0;
      end
   end

   assign spc_ok = pwdata[1:0] != 2'h3 && pwdata[31:2] == 30'h0;
   assign thr_ok = $signed(pwdata[7:0]) <= radio_test_pkg::THRESH_MAX &&
                   $signed(pwdata[7:0]) >= radio_test_pkg::THRESH_MIN;

   // Pre-decoded during setup so the answer leaves flip-flops
   always_comb begin
      bad_wr = 1'b0;
      if (pwrite) begin
         unique case (paddr)
            radio_test_pkg::OFS_SPACING: bad_wr = !spc_ok;
            radio_test_pkg::OFS_TX_FREQ,
            radio_test_pkg::OFS_RX_FREQ: bad_wr = !freq_ok;
            radio_test_pkg::OFS_THRESH: bad_wr = !thr_ok;
            default: bad_wr = 1'b0;
         endcase
      end
   end

   // APB answer: setup cycle loads read data, access cycle completes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0;
      end else begin
         pready_r <= psel && !penable;
         pslverr_r <= 1'b0;
         if (psel && !penable) begin
            prdata_r <= 32'h0;
            unique case (paddr)
               radio_test_pkg::OFS_CTRL: prdata_r <= {30'h0, ctrl_r};
               radio_test_pkg::OFS_SPACING: prdata_r <= {30'h0, spacing_r};
               radio_test_pkg::OFS_TX_FREQ: prdata_r <= tx_freq_r;
               radio_test_pkg::OFS_RX_FREQ: prdata_r <= rx_freq_r;
               radio_test_pkg::OFS_POWER: prdata_r <= {30'h0, power_r};
               radio_test_pkg::OFS_THRESH: prdata_r <= {{24{thresh_r[7]}}, thresh_r};
               radio_test_pkg::OFS_RSSI: prdata_r <= {{24{rssi_dbm[7]}}, rssi_dbm};
               radio_test_pkg::OFS_STATUS: begin
                  prdata_r[radio_test_pkg::STAT_TX_BIT] <= tx_on_r;
                  prdata_r[radio_test_pkg::STAT_BURST_BIT] <= burst_on;
                  prdata_r[radio_test_pkg::STAT_REJ_BIT] <= reject_r;
                  prdata_r[radio_test_pkg::STAT_SEQ_LSB +: 8] <= {seq_hi_r, seq_lo_r};
                  prdata_r[radio_test_pkg::STAT_SEC_LSB +: SECW] <= sec_cnt_r;
               end
               default: pslverr_r <= 1'b1;
            endcase
            if (bad_wr) begin
               pslverr_r <= 1'b1;
            end
         end
      end
   end

   // Settings; refused values keep the old one
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= radio_test_pkg::CTRL_RST;
         spacing_r <= radio_test_pkg::SPC_12K5;
         tx_freq_r <= radio_test_pkg::FREQ_RST_HZ;
         rx_freq_r <= radio_test_pkg::FREQ_RST_HZ;
         power_r <= radio_test_pkg::PWR_1000MW;
         thresh_r <= radio_test_pkg::THRESH_RST;
      end else if (wr_acc) begin
         unique case (woff)
            radio_test_pkg::OFS_CTRL: ctrl_r <= pwdata[1:0];
            radio_test_pkg::OFS_SPACING: begin
               if (spc_ok) begin
                  spacing_r <= pwdata[1:0];
               end
            end
            radio_test_pkg::OFS_TX_FREQ: begin
               if (freq_ok) begin
                  tx_freq_r <= pwdata;
               end
            end
            radio_test_pkg::OFS_RX_FREQ: begin
               if (freq_ok) begin
                  rx_freq_r <= pwdata;
               end
            end
            radio_test_pkg::OFS_POWER: power_r <= pwdata[1:0];
            radio_test_pkg::OFS_THRESH: begin
               if (thr_ok) begin
                  thresh_r <= pwdata[7:0];
               end
            end
            default: ;
         endcase
      end
   end

   // Sticky refusal flag; a new refusal beats a write-one clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reject_r <= 1'b0;
      end else if (wr_acc && pslverr_r && woff != radio_test_pkg::OFS_STATUS) begin
         reject_r <= 1'b1;
      end else if (wr_acc && woff == radio_test_pkg::OFS_STATUS && pwdata[radio_test_pkg::STAT_REJ_BIT]) begin
         reject_r <= 1'b0;
      end
   end

   // Second ticks, restarted whenever control is rewritten
   tick_gen #(
      .CYCLES(SEC_CYCLES)
   ) u_sec (
      .clk(pclk),
      .rst_n(presetn),
      .clr(ctrl_wr),
      .tick_r(sec_tick)
   );

   // Position in the 60 s long-mode cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sec_cnt_r <= '0;
      end else if (ctrl_wr || !test_en || !long_mode) begin
         sec_cnt_r <= '0;
      end else if (sec_tick) begin
         if (sec_cnt_r == CYCLE_LAST) begin
            sec_cnt_r <= '0;
         end else begin
            sec_cnt_r <= sec_cnt_r + 1'b1;
         end
      end
   end

   assign burst_on = test_en && long_mode && sec_cnt_r < BURST_END;

   // A line is due at once after reset or enable, then every second
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         line_due_r <= 1'b1;
      end else if (ctrl_wr) begin
         line_due_r <= 1'b1;
      end else if (sec_tick) begin
         line_due_r <= 1'b1;
      end else if (line_start) begin
         line_due_r <= 1'b0;
      end
   end

   // Short lines wait for the second; long lines run back to back
   assign line_start = state_r == radio_test_pkg::S_IDLE && test_en &&
                       (long_mode ? burst_on : line_due_r);
   assign line_done = state_r == radio_test_pkg::S_BODY && tx_ready &&
                      idx_r == (long_mode ? LONG_LAST : SHORT_LAST);

   // Decimal sequence number, advanced per completed line
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seq_hi_r <= 4'h0;
         seq_lo_r <= 4'h0;
      end else if (line_done) begin
         if (seq_lo_r == radio_test_pkg::SEQ_DIGIT_MAX) begin
            seq_lo_r <= 4'h0;
            if (seq_hi_r == radio_test_pkg::SEQ_DIGIT_MAX) begin
               seq_hi_r <= 4'h0;
            end else begin
               seq_hi_r <= seq_hi_r + 1'b1;
            end
         end else begin
            seq_lo_r <= seq_lo_r + 1'b1;
         end
      end
   end

   text_rom #(
      .DEPTH(radio_test_pkg::TEXT_LEN),
      .WIDTH(8),
      .AW(AW),
      .INIT(radio_test_pkg::TEXT)
   ) u_text (
      .clk(pclk),
      .rst_n(presetn),
      .addr((long_mode ? LONG_BASE : SHORT_BASE) + idx_r),
      .data_r(rom_data)
   );

   // Line sender; disabling test mode abandons the line in progress
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= radio_test_pkg::S_IDLE;
         tx_data_r <= 8'h00;
         tx_valid_r <= 1'b0;
         idx_r <= '0;
      end else if (!test_en) begin
         state_r <= radio_test_pkg::S_IDLE;
         tx_valid_r <= 1'b0;
         idx_r <= '0;
      end else begin
         unique case (state_r)
            radio_test_pkg::S_IDLE: begin
               if (line_start) begin
                  tx_data_r <= radio_test_pkg::ASCII_ZERO + {4'h0, seq_hi_r};
                  tx_valid_r <= 1'b1;
                  state_r <= radio_test_pkg::S_DIG_HI;
               end
            end
            radio_test_pkg::S_DIG_HI: begin
               if (tx_ready) begin
                  tx_data_r <= radio_test_pkg::ASCII_ZERO + {4'h0, seq_lo_r};
                  state_r <= radio_test_pkg::S_DIG_LO;
               end
            end
            radio_test_pkg::S_DIG_LO: begin
               if (tx_ready) begin
                  tx_valid_r <= 1'b0;
                  idx_r <= '0;
                  state_r <= radio_test_pkg::S_FETCH;
               end
            end
            radio_test_pkg::S_FETCH: begin
               state_r <= radio_test_pkg::S_LOAD;
            end
            radio_test_pkg::S_LOAD: begin
               tx_data_r <= rom_data;
               tx_valid_r <= 1'b1;
               state_r <= radio_test_pkg::S_BODY;
            end
            radio_test_pkg::S_BODY: begin
               if (tx_ready) begin
                  tx_valid_r <= 1'b0;
                  if (line_done) begin
                     idx_r <= '0;
                     state_r <= radio_test_pkg::S_IDLE;
                  end else begin
                     idx_r <= idx_r + 1'b1;
                     state_r <= radio_test_pkg::S_FETCH;
                  end
               end
            end
            default: state_r <= radio_test_pkg::S_IDLE;
         endcase
      end
   end

   // Carrier keyed for a whole burst in long mode, per line in short mode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_on_r <= 1'b0;
         transmit_data_indicator_r <= 1'b0;
      end else begin
         tx_on_r <= test_en && (long_mode ? (burst_on || state_r != radio_test_pkg::S_IDLE)
                                          : state_r != radio_test_pkg::S_IDLE);
         transmit_data_indicator_r <= test_en;
      end
   end

   // Level decided once at frame start, held for the whole frame
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_frame_d_r <= 1'b0;
         rx_pass_r <= 1'b0;
      end else begin
         rx_frame_d_r <= rx_frame;
         if (!rx_frame) begin
            rx_pass_r <= 1'b0;
         end else if (!rx_frame_d_r) begin
            rx_pass_r <= rssi_dbm >= thresh_r;
         end
      end
   end

endmodule

// ### rtl/radio_test_pkg.sv
/*
 Constants shared by the radio test-message generator: register map,
 reset values, setting encodings, timing counts and the test text.
 Assumes a 100 MHz pclk and 32-bit APB data with word-aligned registers.
*/
package radio_test_pkg;

   // Timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int SEC_NS = 1_000_000_000;
   localparam int SEC_CYCLES = SEC_NS / CLK_PERIOD_NS;
   localparam int LINE_PERIOD_S = 1;
   localparam int BURST_S = 50;
   localparam int PAUSE_S = 10;

   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_SPACING = 8'h04;
   localparam logic [7:0] OFS_TX_FREQ = 8'h08;
   localparam logic [7:0] OFS_RX_FREQ = 8'h0c;
   localparam logic [7:0] OFS_POWER = 8'h10;
   localparam logic [7:0] OFS_THRESH = 8'h14;
   localparam logic [7:0] OFS_RSSI = 8'h18;
   localparam logic [7:0] OFS_STATUS = 8'h1c;

   // Control fields
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_LONG_BIT = 1;
   localparam logic [1:0] CTRL_RST = 2'h1;

   // Channel spacing codes
   localparam logic [1:0] SPC_12K5 = 2'h0;
   localparam logic [1:0] SPC_20K = 2'h1;
   localparam logic [1:0] SPC_25K = 2'h2;

   // Transmit power codes: 100, 200, 500, 1000 mW
   localparam logic [1:0] PWR_100MW = 2'h0;
   localparam logic [1:0] PWR_1000MW = 2'h3;

   // Frequencies in Hz
   localparam logic [31:0] FREQ_STEP_FINE_HZ = 32'h0000_186a;
   localparam logic [31:0] FREQ_STEP_WIDE_HZ = 32'h0000_2710;
   localparam logic [31:0] FREQ_RST_HZ = 32'h1659_f3e0;

   // Signal threshold, signed dBm
   localparam logic signed [7:0] THRESH_MAX = -8'sd80;
   localparam logic signed [7:0] THRESH_MIN = -8'sd118;
   localparam logic signed [7:0] THRESH_RST = -8'sd115;

   // Status fields
   localparam int STAT_TX_BIT = 0;
   localparam int STAT_BURST_BIT = 1;
   localparam int STAT_REJ_BIT = 2;
   localparam int STAT_SEQ_LSB = 8;
   localparam int STAT_SEC_LSB = 16;

   // Sequence number
   localparam logic [3:0] SEQ_DIGIT_MAX = 4'h9;
   localparam logic [7:0] ASCII_ZERO = 8'h30;

   // Test text: short body then long body, each ending CR LF
   localparam int SHORT_LEN = 18;
   localparam int LONG_LEN = 32;
   localparam int TEXT_LEN = SHORT_LEN + LONG_LEN;
   localparam logic [8*TEXT_LEN-1:0] TEXT = {
      " SHORT TEST LINE", 8'h0d, 8'h0a,
      " LONG TEST LINE OF RADIO MODEM", 8'h0d, 8'h0a};

   typedef enum logic [2:0] {
      S_IDLE, S_DIG_HI, S_DIG_LO, S_FETCH, S_LOAD, S_BODY
   } send_state_t;

endpackage

// ### rtl/text_rom.sv
/*
 Small constant text store with a registered read port.
 Assumes the caller holds the address one cycle before using the data.
*/
`timescale 1ns/1ps
module text_rom #(
   parameter int DEPTH = 50,
   parameter int WIDTH = 8,
   parameter int AW = 6,
   parameter logic [DEPTH*WIDTH-1:0] INIT = '0
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Read port
   input wire logic [AW-1:0] addr,
   output logic [WIDTH-1:0] data_r
);

   initial begin
      if (DEPTH > (1 << AW)) begin
         $error("text_rom: DEPTH does not fit AW");
      end
   end

   // First entry sits in the top bits of INIT
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         data_r <= '0;
      end else if (int'(addr) < DEPTH) begin
         data_r <= INIT[(DEPTH - 1 - int'(addr)) * WIDTH +: WIDTH];
      end else begin
         data_r <= '0;
      end
   end

endmodule

// ### rtl/tick_gen.sv
/*
 Periodic one-cycle tick after every CYCLES clocks, restartable.
 Assumes clr comes from logic on the same clock.
*/
`timescale 1ns/1ps
module tick_gen #(
   parameter int CYCLES = 100
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Control and tick
   input wire logic clr,
   output logic tick_r
);

   localparam int CW = (CYCLES > 1) ? $clog2(CYCLES) : 1;
   localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

   logic [CW-1:0] cnt_r;

   initial begin
      if (CYCLES < 2) begin
         $error("tick_gen: CYCLES must be at least 2");
      end
   end

   // Restart clears both count and pending tick
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= '0;
         tick_r <= 1'b0;
      end else if (clr) begin
         cnt_r <= '0;
         tick_r <= 1'b0;
      end else if (cnt_r == LAST) begin
         cnt_r <= '0;
         tick_r <= 1'b1;
      end else begin
         cnt_r <= cnt_r + 1'b1;
         tick_r <= 1'b0;
      end
   end

endmodule
